// >>> lcpa_pkg.sv
package lcpa_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_FDBK_LO = 8'h02;
	localparam logic [7:0] REG_FDBK_HI = 8'h03;
	localparam logic [7:0] REG_PH_OFS  = 8'h04;
	localparam logic [7:0] REG_PH_RES  = 8'h05;

	// ------------------------------------------------------------
	// field widths and reset values
	// ------------------------------------------------------------
	localparam int         DIV_W       = 12;
	localparam int         CNT_W       = 13;
	localparam int         HI_W        = 4;
	localparam int         OFS_W       = 6;
	localparam int         RES_W       = 2;
	localparam logic [7:0] RST_FDBK_LO = 8'hFF;
	localparam logic [3:0] RST_FDBK_HI = 4'h0;
	localparam logic [5:0] RST_OFS     = 6'h00;
	localparam logic [1:0] RST_RES     = 2'h0;
	localparam logic [7:0] RDATA_ZERO  = 8'h00;

	// extra pixel clocks added to the programmed divider
	localparam logic [12:0] FDBK_EXTRA = 13'h0008;

	// ------------------------------------------------------------
	// resolution codes and per-period unit masks
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LCPA_RES_16   = 2'h0,
		LCPA_RES_32   = 2'h1,
		LCPA_RES_RSVD = 2'h2,
		LCPA_RES_64   = 2'h3
	} lcpa_res_t;

	localparam logic [5:0] MASK_16 = 6'h0F;
	localparam logic [5:0] MASK_32 = 6'h1F;
	localparam logic [5:0] MASK_64 = 6'h3F;

	// last delay unit of a pixel period for a resolution code
	function automatic logic [5:0] lcpa_unit_mask(input logic [1:0] res);
		case (lcpa_res_t'(res))
			LCPA_RES_16: lcpa_unit_mask = MASK_16;
			LCPA_RES_32: lcpa_unit_mask = MASK_32;
			LCPA_RES_64: lcpa_unit_mask = MASK_64;
			default:     lcpa_unit_mask = MASK_16; // reserved code
		endcase
	endfunction : lcpa_unit_mask

endpackage : lcpa_pkg

// >>> lcpa_phase_if.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// link between control and phase generator
// ------------------------------------------------------------
interface lcpa_phase_if;
	logic [5:0] unit_mask;  // last unit index of a pixel period
	logic [5:0] offset;     // applied phase offset in units
	logic [5:0] unit_mask_nxt; // unit mask that governs the next unit
	logic [5:0] offset_nxt;    // offset that governs the next unit
	logic       period_end; // last unit of a pixel period
	logic       pix_clk;    // phase-shifted pixel clock level

	modport gen (
		input  unit_mask,
		input  offset,
		input  unit_mask_nxt,
		input  offset_nxt,
		output period_end,
		output pix_clk
	);
	modport ctl (
		output unit_mask,
		output offset,
		output unit_mask_nxt,
		output offset_nxt,
		input  period_end,
		input  pix_clk
	);
endinterface : lcpa_phase_if

`default_nettype wire

// >>> lcpa_phase_gen.sv
`timescale 1ns/1ns
`default_nettype none

module lcpa_phase_gen
	import lcpa_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// control side
	lcpa_phase_if.gen ph
);

	// ------------------------------------------------------------
	// delay unit counter
	// ------------------------------------------------------------
	logic [5:0] unit_r;
	logic [5:0] unit_nxt;
	logic [5:0] rel_nxt;
	logic [5:0] half_w;
	logic       pix_clk_r;
	logic       pix_clk_nxt;

	// one pixel period is unit_mask+1 delay units
	assign ph.period_end = (unit_r == ph.unit_mask);
	assign unit_nxt      = ph.period_end ? '0 : unit_r + 6'h01;
	// position of the next unit relative to the delayed rising edge
	// next settings keep the first unit of a new line free of a stale level
	assign rel_nxt       = (unit_nxt - ph.offset_nxt)
		& ph.unit_mask_nxt;
	assign half_w        = (ph.unit_mask_nxt >> 1) + 6'h01;
	assign pix_clk_nxt   = (rel_nxt < half_w);
	assign ph.pix_clk    = pix_clk_r;

	// counter and registered clock level
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			unit_r    <= '1; // wraps to unit 0 on the first edge
			pix_clk_r <= 1'b0;
		end else begin
			unit_r    <= unit_nxt;
			pix_clk_r <= pix_clk_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_rise_at_offset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($rose(pix_clk_r) && $stable(ph.offset) && $stable(ph.unit_mask))
			|-> (unit_r == ph.offset))
		else $error("pixel clock rose away from the phase offset");

	chk_high_at_offset: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		(unit_r == ph.offset) |-> pix_clk_r)
		else $error("pixel clock low in the offset unit");

	chk_unit_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ph.period_end |=> (unit_r == 6'h00) ##1 (unit_r == 6'h01))
		else $error("delay unit counter did not restart");

endmodule : lcpa_phase_gen

`default_nettype wire

// >>> lcpa_clock_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - the 12-bit divider is the low nibble of 0x03 placed above the byte in 0x02.
// - each line holds the divider value plus eight pixel clock periods.
// - the offset in 0x04 bits 5..0 delays the pixel clock rise after sync rise.
// - the offset runs in unit steps from zero to one period less one unit.
// - a unit is one pixel period divided by the selected number of units.
// - resolution code 0, 1, 3 selects 16, 32, 64 units; code 2 is reserved.
// - reset clears divider high bits, phase offset and phase resolution.
// - the divider low byte resets to all ones; its bit 0 marks an odd total.
module lcpa_clock_ctrl
	import lcpa_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register access behind the serial port
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// clock outputs
	output logic            pix_clk_o,
	output logic            hsync_rec_o
);

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	logic [7:0]       fdbk_lo_r;
	logic [HI_W-1:0]  fdbk_hi_r;
	logic [OFS_W-1:0] ofs_r;
	logic [RES_W-1:0] res_r;
	logic             wr_lo_w;
	logic             wr_hi_w;
	logic             wr_ofs_w;
	logic             wr_res_w;
	logic [7:0]       rd_mux_w;

	assign wr_lo_w  = reg_wr_i && (reg_addr_i == REG_FDBK_LO);
	assign wr_hi_w  = reg_wr_i && (reg_addr_i == REG_FDBK_HI);
	assign wr_ofs_w = reg_wr_i && (reg_addr_i == REG_PH_OFS);
	assign wr_res_w = reg_wr_i && (reg_addr_i == REG_PH_RES);

	// read mux, reserved bits and unmapped offsets read zero
	assign rd_mux_w =
		(reg_addr_i == REG_FDBK_LO) ? fdbk_lo_r :
		(reg_addr_i == REG_FDBK_HI) ? {4'h0, fdbk_hi_r} :
		(reg_addr_i == REG_PH_OFS)  ? {2'h0, ofs_r} :
		(reg_addr_i == REG_PH_RES)  ? {6'h00, res_r} :
		RDATA_ZERO;

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fdbk_lo_r <= RST_FDBK_LO;
			fdbk_hi_r <= RST_FDBK_HI;
			ofs_r     <= RST_OFS;
			res_r     <= RST_RES;
		end else begin
			if (wr_lo_w)  fdbk_lo_r <= reg_wdata_i;
			if (wr_hi_w)  fdbk_hi_r <= reg_wdata_i[HI_W-1:0];
			if (wr_ofs_w) ofs_r     <= reg_wdata_i[OFS_W-1:0];
			if (wr_res_w) res_r     <= reg_wdata_i[RES_W-1:0];
		end
	end

	// registered read data
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= RDATA_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux_w;
		end
	end

	// ------------------------------------------------------------
	// double-buffered working copies, taken at each line end
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_w;
	logic [DIV_W-1:0] div_act_r;
	logic [OFS_W-1:0] ofs_act_r;
	logic [RES_W-1:0] res_act_r;
	logic [CNT_W-1:0] modulus_w;
	logic [CNT_W-1:0] pix_cnt_r;
	logic [CNT_W-1:0] pix_cnt_nxt;
	logic             line_end_w;
	logic             sync_r;

	lcpa_phase_if ph ();

	assign div_w      = {fdbk_hi_r, fdbk_lo_r};
	assign modulus_w  = {1'b0, div_act_r} + FDBK_EXTRA;
	assign line_end_w = ph.period_end && (pix_cnt_r == modulus_w - 13'h0001);
	assign pix_cnt_nxt = line_end_w ? '0 :
		(ph.period_end ? pix_cnt_r + 13'h0001 : pix_cnt_r);

	// units per period and offset kept inside one period
	assign ph.unit_mask = lcpa_unit_mask(res_act_r);
	assign ph.offset    = ofs_act_r & ph.unit_mask;

	// settings for the next unit, the written ones at a line end
	assign ph.unit_mask_nxt = line_end_w ? lcpa_unit_mask(res_r)
		: ph.unit_mask;
	assign ph.offset_nxt    = line_end_w ? (ofs_r & ph.unit_mask_nxt)
		: ph.offset;

	// phase_double_buffered: new settings apply at a line boundary
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_act_r <= {RST_FDBK_HI, RST_FDBK_LO};
			ofs_act_r <= RST_OFS;
			res_act_r <= RST_RES;
		end else if (line_end_w) begin
			div_act_r <= div_w;
			ofs_act_r <= ofs_r;
			res_act_r <= res_r;
		end
	end

	// ------------------------------------------------------------
	// feedback counter and recovered sync
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pix_cnt_r <= '0;
			sync_r    <= 1'b0;
		end else begin
			pix_cnt_r <= pix_cnt_nxt;
			sync_r    <= line_end_w;
		end
	end

	assign hsync_rec_o = sync_r;

	// pixel clock straight from the generator's flop
	assign pix_clk_o = ph.pix_clk;

	lcpa_phase_gen u_phase (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ph      (ph)
	);

	// ------------------------------------------------------------
	// check helpers
	// ------------------------------------------------------------
	logic [CNT_W-1:0] per_cnt_h;
	logic [CNT_W-1:0] line_mod_h;
	logic             line_seen_h;

	// pixel periods since the last recovered sync
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			per_cnt_h   <= '0;
			line_mod_h  <= '0;
			line_seen_h <= 1'b0;
		end else if (sync_r) begin
			per_cnt_h   <= ph.period_end ? 13'h0001 : '0;
			line_mod_h  <= modulus_w;
			line_seen_h <= 1'b1;
		end else if (ph.period_end) begin
			per_cnt_h   <= per_cnt_h + 13'h0001;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_reset_clears: assert property (disable iff (1'b0)
		!rst_n_i |=> (fdbk_hi_r == RST_FDBK_HI) && (ofs_r == RST_OFS)
			&& (res_r == RST_RES))
		else $error("reset did not clear control fields");

	chk_reset_lo_ones: assert property (disable iff (1'b0)
		!rst_n_i |=> (fdbk_lo_r == RST_FDBK_LO))
		else $error("divider low byte not all ones after reset");

	chk_div_high_bits: assert property (
		wr_hi_w |=> (div_w[11:8] == $past(reg_wdata_i[3:0]))
			&& $stable(div_w[7:0]))
		else $error("divider high nibble not taken from write");

	chk_line_length: assert property (
		(sync_r && line_seen_h) |-> (per_cnt_h == line_mod_h))
		else $error("pixel periods per line differ from divider plus eight");

	chk_res_applied: assert property (
		line_end_w |=> (ph.unit_mask == lcpa_unit_mask($past(res_r))))
		else $error("resolution not applied at line end");

	chk_ofs_range: assert property (
		ph.offset <= ph.unit_mask)
		else $error("phase offset reaches a full period");

	chk_rsvd_read_zero: assert property (
		(reg_rd_i && (reg_addr_i == REG_FDBK_HI)) |=> (reg_rdata_o[7:4] == 4'h0))
		else $error("reserved divider bits read nonzero");

	chk_lo_readback: assert property (
		(reg_rd_i && (reg_addr_i == REG_FDBK_LO)) |=>
			(reg_rdata_o == $past(fdbk_lo_r)))
		else $error("divider low byte readback wrong");

	chk_shadow_hold: assert property (
		!$past(line_end_w) |-> ($stable(div_act_r) && $stable(ofs_act_r)))
		else $error("working settings changed inside a line");

	chk_sync_single: assert property (
		sync_r |=> !sync_r)
		else $error("recovered sync longer than one cycle");

	cov_res_64: cover property (line_end_w && (res_r == LCPA_RES_64));
	cov_res_32_ofs: cover property ($rose(pix_clk_o) && (ph.offset == MASK_32));
	cov_two_lines: cover property (sync_r ##[1:1000] sync_r);

endmodule : lcpa_clock_ctrl

`default_nettype wire

// >>> lcpa_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// host side of the register port
// ------------------------------------------------------------
module lcpa_host_model (
	// clock
	input  wire logic       clk_i,
	// register strobes
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	// idle bus at time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// one write strobe; released lines show inverted values
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_o    <= 1'b1;
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask : write

	// one read strobe; data is valid just after return
	task automatic read(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_o   <= 1'b1;
		reg_addr_o <= a;
		@(posedge clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
	endtask : read
endmodule : lcpa_host_model

`default_nettype wire

// >>> line_clock_divider_phase_adjust_bench.sv
`timescale 1ns/1ns
`default_nettype none

module line_clock_divider_phase_adjust_bench;
	import lcpa_pkg::*;

	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] q;
	} lcpa_row_t;

	// ------------------------------------------------------------
	// clock, reset and wires
	// ------------------------------------------------------------
	logic       clk   = 1'b0;
	logic       rst_n = 1'b0;
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       pix;
	logic       sync;
	logic       pix_d = 1'b0;
	int         fails = 0;
	int         checks = 0;
	int         units [4] = '{16, 32, 16, 64};
	lcpa_row_t  rows [7] = '{
		'{8'h03, 8'hFA, 8'h0A}, '{8'h04, 8'hC5, 8'h05},
		'{8'h05, 8'hFE, 8'h02}, '{8'h05, 8'h03, 8'h03},
		'{8'h02, 8'h10, 8'h10}, '{8'h07, 8'h55, 8'h00},
		'{8'h01, 8'hAA, 8'h00}};

	// clock and delayed pixel clock
	always #5 clk = ~clk;
	always @(posedge clk) pix_d <= pix;

	// design and host
	lcpa_clock_ctrl u_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .pix_clk_o(pix), .hsync_rec_o(sync));
	lcpa_host_model u_host (.clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_addr_o(addr), .reg_wdata_o(wdata));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] q);
		u_host.read(a);
		#1;
		chk({8'h00, rdata}, {8'h00, q});
	endtask : rd_chk

	task automatic defaults();
		rd_chk(REG_FDBK_LO, 8'hFF);
		rd_chk(REG_FDBK_HI, 8'h00);
		rd_chk(REG_PH_OFS, 8'h00);
		rd_chk(REG_PH_RES, 8'h00);
	endtask : defaults

	// advance to the next recovered sync pulse
	task automatic sync_wait();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (sync !== 1'b1 && i < 5000);
		if (i >= 5000) begin
			fails++;
			tally_and_finish();
		end
	endtask : sync_wait

	// line length and pixel clock rise position from one sync
	task automatic measure(input int len, input int ofs);
		int n;
		int rise;
		n = 0;
		rise = -1;
		do begin
			if (rise < 0 && pix === 1'b1 && pix_d === 1'b0) rise = n;
			@(posedge clk);
			#1;
			n++;
		end while (sync !== 1'b1 && n < 5000);
		chk(16'(n), 16'(len));
		chk(16'(rise), 16'(ofs));
		if (n >= 5000) begin
			fails++;
			tally_and_finish();
		end
	endtask : measure

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		defaults();
		sync_wait();
		measure(263 * 16, 0);
		foreach (rows[i]) begin
			u_host.write(rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].q);
		end
		// divider using the high nibble
		u_host.write(REG_FDBK_LO, 8'h03);
		u_host.write(REG_FDBK_HI, 8'h01);
		u_host.write(REG_PH_OFS, 8'h05);
		u_host.write(REG_PH_RES, 8'h00);
		sync_wait();
		sync_wait(); // skip the line in which new settings take over
		measure(267 * 16, 5);
		// every resolution code at the largest offset
		u_host.write(REG_FDBK_LO, 8'h04);
		u_host.write(REG_FDBK_HI, 8'h00);
		u_host.write(REG_PH_OFS, 8'h3F);
		for (int c = 0; c < 4; c++) begin
			u_host.write(REG_PH_RES, 8'(c));
			sync_wait();
			sync_wait(); // skip the line in which new settings take over
			measure(12 * units[c], 63 & (units[c] - 1));
		end
		// reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({6'h00, pix, sync, rdata}, 16'h0000);
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		defaults();
		tally_and_finish();
	end
endmodule : line_clock_divider_phase_adjust_bench

`default_nettype wire
